// ===== i2c_target_register_read.sv
// Read half of a two-wire target port: pointer write, repeated start, sequential byte reads.
// Functional notes
// - First byte is pointer location, MSB first.
// - Pointer advances after LSB; next byte ready.
// - Past top address, every byte reads FFh.
// - Reserved locations may return any value.
// - Answer only address 0110110, ack after R/W.
// - R/W of one selects device-to-host bytes.
// - Device drives SDA except host acknowledge cycles.
// - Eight bits MSB first, then one acknowledge.
`timescale 1ns/100ps
`default_nettype none
module i2c_target_register_read
	import fg_read_pkg::*;
(
	input wire logic i_clock, // System clock, 40 MHz.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic i_clk_en, // Freezes system-domain state while low.
	input wire logic i_scl, // Serial clock from the host; clocks the link logic.
	input wire logic i_sda, // Resolved level of the data line.
	output logic o_sda_o, // Data line drive value (always low, open drain).
	output logic o_sda_oe, // High while pulling the data line low.
	input wire logic [7:0] i_rd_data, // Byte returned by the register map.
	output logic o_rd_en, // One-cycle read strobe to the register map.
	output logic [7:0] o_rd_addr // Register map address.
);

	link_state_t state_q;
	logic start_tgl_q;
	logic start_seen_q;
	logic [2:0] cnt_q;
	logic [6:0] shift_q;
	logic [7:0] in_byte;
	logic [PTR_W-1:0] ptr_q;
	logic [PTR_W-1:0] ptr_next;
	fetch_req_t req_q;
	logic [7:0] held_byte;
	logic pull_q;
	logic [6:0] tx_sh_q;
	logic start_pend;

	// The counter, the byte length and the overflow bit of the pointer are tied together; any
	// other package values would break the pointer arithmetic without a visible error.
	if (BYTE_BITS != 8) begin : g_bad_byte
		$error("byte length must be eight bits");
	end
	if (LAST_BIT != 3'(BYTE_BITS - 1)) begin : g_bad_last
		$error("last bit index does not match the byte length");
	end
	if (PTR_W != PTR_OVF_BIT + 1) begin : g_bad_ptr
		$error("pointer must be one bit wider than the byte address");
	end
	if (PTR_PAST_TOP != 9'(1 << PTR_OVF_BIT)) begin : g_bad_top
		$error("past-top pointer must set only the overflow bit");
	end

	// A start is the only falling data edge while the clock is high. It is caught on the data
	// line itself because the serial clock has no rising edge between the start and the first bit.
	always_ff @(negedge i_sda or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_tgl_q <= 1'b0;
		end else if (i_scl) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	// The toggle settles a full set-up time before the next clock rise, so it is compared directly.
	assign start_pend = (start_tgl_q != start_seen_q);
	assign in_byte = {shift_q, i_sda};

	// Once past the top the pointer sticks there, so every later byte reads as the filler value.
	always_comb begin
		if (ptr_q[PTR_OVF_BIT]) begin
			ptr_next = PTR_PAST_TOP;
		end else begin
			ptr_next = ptr_q + 9'h001;
		end
	end

	// Receive shift register: the last seven bits taken, so that in_byte is whole at the eighth.
	always_ff @(posedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shift_q <= 7'h00;
		end else if (start_pend) begin
			shift_q <= {6'h00, i_sda};
		end else begin
			shift_q <= in_byte[6:0];
		end
	end

	// Sampling side of the link: bits are taken on the rising clock.
	always_ff @(posedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
			start_seen_q <= 1'b0;
			cnt_q <= 3'h0;
		end else if (start_pend) begin
			start_seen_q <= start_tgl_q;
			state_q <= ST_ADDR;
			cnt_q <= 3'h1;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			unique case (state_q)
				ST_IDLE: begin
					cnt_q <= 3'h0;
				end
				ST_ADDR: begin
					if (cnt_q == LAST_BIT) begin
						state_q <= (in_byte[7:1] == TARGET_ADDR) ? ST_ADDR_ACK : ST_IDLE;
					end
				end
				ST_ADDR_ACK: begin
					cnt_q <= 3'h0;
					state_q <= (shift_q[0] == RW_READ) ? ST_TX : ST_PTR;
				end
				ST_PTR: begin
					if (cnt_q == LAST_BIT) begin
						state_q <= ST_PTR_ACK;
					end
				end
				ST_PTR_ACK: begin
					state_q <= ST_IDLE;
				end
				ST_TX: begin
					if (cnt_q == LAST_BIT) begin
						state_q <= ST_TX_ACK;
					end
				end
				ST_TX_ACK: begin
					cnt_q <= 3'h0;
					state_q <= i_sda ? ST_IDLE : ST_TX;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Register pointer: loaded by the pointer byte, stepped after the last bit of each sent byte.
	always_ff @(posedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr_q <= PTR_RESET;
		end else if (!start_pend) begin
			if (state_q == ST_PTR && cnt_q == LAST_BIT) begin
				ptr_q <= {1'b0, in_byte};
			end else if (state_q == ST_TX && cnt_q == LAST_BIT) begin
				ptr_q <= ptr_next;
			end
		end
	end

	// Prefetch requests. The next byte is fetched one bit into the current one, which leaves
	// eight serial clocks for the system domain to answer. The address is set in the same edge
	// as the toggle and then stands for at least nine serial clocks.
	always_ff @(posedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_q <= '0;
		end else if (!start_pend) begin
			if (state_q == ST_PTR && cnt_q == LAST_BIT) begin
				req_q.addr <= {1'b0, in_byte};
				req_q.tgl <= ~req_q.tgl;
			end else if (state_q == ST_TX && cnt_q == 3'h0) begin
				req_q.addr <= ptr_next;
				req_q.tgl <= ~req_q.tgl;
			end
		end
	end

	// Driving side of the link: the line changes only while the clock is low.
	always_ff @(negedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pull_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_ADDR_ACK, ST_PTR_ACK: begin
					pull_q <= 1'b1;
				end
				ST_TX: begin
					if (cnt_q == 3'h0) begin
						pull_q <= ~held_byte[7];
					end else begin
						pull_q <= ~tx_sh_q[6];
					end
				end
				default: begin
					pull_q <= 1'b0;
				end
			endcase
		end
	end

	// Transmit shift register: loaded from the held byte as its top bit goes out, then shifted.
	always_ff @(negedge i_scl or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_sh_q <= 7'h00;
		end else if (state_q == ST_TX && cnt_q == 3'h0) begin
			tx_sh_q <= held_byte[6:0];
		end else if (state_q == ST_TX) begin
			tx_sh_q <= {tx_sh_q[5:0], 1'b0};
		end
	end

	// Held byte is stable for several serial clocks before it is loaded, so no synchroniser is
	// needed on the way back; a host clock far above the bench rate would break that margin.
	fetch_port u_fetch (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_req(req_q),
		.i_rd_data(i_rd_data),
		.o_rd_en(o_rd_en),
		.o_rd_addr(o_rd_addr),
		.o_byte(held_byte)
	);

	assign o_sda_o = 1'b0;
	assign o_sda_oe = pull_q;

endmodule
`default_nettype wire

// ===== fg_read_pkg.sv
// Shared constants and types for the register-read target port.
package fg_read_pkg;

	// Bus-facing constants.
	localparam logic [6:0] TARGET_ADDR = 7'h36;
	localparam logic RW_READ = 1'b1;
	localparam logic [7:0] PAST_TOP_BYTE = 8'hFF;
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Pointer layout: bit 8 set means the pointer has moved past the top address.
	localparam int PTR_W = 9;
	localparam int PTR_OVF_BIT = 8;
	localparam logic [8:0] PTR_RESET = 9'h000;
	localparam logic [8:0] PTR_PAST_TOP = 9'h100;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// Fetch request from the link domain to the system domain.
	typedef struct packed {
		logic tgl;
		logic [PTR_W-1:0] addr;
	} fetch_req_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_PTR = 3'b011,
		ST_PTR_ACK = 3'b100,
		ST_TX = 3'b101,
		ST_TX_ACK = 3'b110
	} link_state_t;

endpackage

// ===== fetch_port.sv
// System-domain side of the byte fetch: catches a link request and holds the fetched byte.
`timescale 1ns/100ps
`default_nettype none
module fetch_port
	import fg_read_pkg::*;
(
	input wire logic i_clock, // System clock.
	input wire logic i_rst_n, // Asynchronous reset, active low.
	input wire logic i_clk_en, // Freezes all state while low.
	input wire fetch_req_t i_req, // Request from the link domain.
	input wire logic [7:0] i_rd_data, // Byte from the register map.
	output logic o_rd_en, // One-cycle read strobe.
	output logic [7:0] o_rd_addr, // Register address being read.
	output logic [7:0] o_byte // Byte held for the link domain.
);

	logic sync1_q, sync2_q, seen_q;
	logic rd_en_q;
	logic past_top_q;
	logic [7:0] addr_q;
	logic [7:0] byte_q;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			seen_q <= 1'b0;
		end else if (i_clk_en) begin
			sync1_q <= i_req.tgl;
			sync2_q <= sync1_q;
			seen_q <= sync2_q;
		end
	end

	// The address field has been stable for two clocks once the toggle shows up, so it is taken directly.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_en_q <= 1'b0;
			addr_q <= DATA_RESET;
			past_top_q <= 1'b0;
		end else if (i_clk_en) begin
			rd_en_q <= (sync2_q != seen_q) && !i_req.addr[PTR_OVF_BIT];
			if (sync2_q != seen_q) begin
				past_top_q <= i_req.addr[PTR_OVF_BIT];
			end
			// The map address only moves with a strobe, so a read past the top leaves it alone.
			if (sync2_q != seen_q && !i_req.addr[PTR_OVF_BIT]) begin
				addr_q <= i_req.addr[7:0];
			end
		end
	end

	// Reserved locations are passed through unchanged from the map.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			byte_q <= DATA_RESET;
		end else if (i_clk_en) begin
			if (past_top_q) begin
				byte_q <= PAST_TOP_BYTE;
			end else if (rd_en_q) begin
				byte_q <= i_rd_data;
			end
		end
	end

	assign o_rd_en = rd_en_q;
	assign o_rd_addr = addr_q;
	assign o_byte = byte_q;

endmodule
`default_nettype wire

// ===== fg_read_chk_sva.sv
// Concurrent checks on the pins of the register-read target port.
`timescale 1ns/100ps
`default_nettype none
module fg_read_chk (
	input wire logic i_clock, // Watched.
	input wire logic i_rst_n, // Watched.
	input wire logic i_clk_en, // Watched.
	input wire logic i_scl, // Watched.
	input wire logic i_sda, // Watched.
	input wire logic o_sda_o, // Watched.
	input wire logic o_sda_oe, // Watched.
	input wire logic [7:0] i_rd_data, // Watched.
	input wire logic o_rd_en, // Watched.
	input wire logic [7:0] o_rd_addr // Watched.
);
	pulse_one_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_rd_en |=> !o_rd_en) else $error("read strobe too long");
	fetch_gap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		$rose(o_rd_en) |=> !o_rd_en [*8]) else $error("fetches too close");
	addr_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_rd_en |=> $stable(o_rd_addr)) else $error("address moved");
	addr_cause_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		$changed(o_rd_addr) |-> o_rd_en) else $error("address changed without strobe");
	open_drain_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!o_sda_o) else $error("data line driven high");
	edge_only_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		$changed(o_sda_oe) |-> !i_scl) else $error("data moved while clock high");
	run_only_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		$rose(o_rd_en) |-> $past(i_clk_en)) else $error("strobe while frozen");
	// Address ack plus eight low bits is the longest legal drive before an ack slot.
	ack_gap_a: assert property (@(posedge i_scl) disable iff (!i_rst_n)
		o_sda_oe [*8] ##1 o_sda_oe |=> !o_sda_oe) else $error("ack slot not released");
endmodule
bind i2c_target_register_read fg_read_chk u_chk (.i_clock, .i_rst_n, .i_clk_en, .i_scl, .i_sda,
	.o_sda_o, .o_sda_oe, .i_rd_data, .o_rd_en, .o_rd_addr);
`default_nettype wire

// ===== fg_host_model.sv
// Behavioural two-wire host that writes a pointer and reads bytes back.
`timescale 1ns/100ps
`default_nettype none
module fg_host_model (
	input wire logic i_sda, // Resolved data line.
	output logic o_scl, // Serial clock, high between frames.
	output logic o_sda_pull // High while pulling the data line low.
);
	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
	end
	task automatic put_bit(input logic b);
		o_sda_pull = !b;
		#20 o_scl = 1'b1;
		#40 o_scl = 1'b0;
		#20;
	endtask
	task automatic get_bit(output logic b);
		o_sda_pull = 1'b0;
		#20 o_scl = 1'b1;
		#20 b = i_sda;
		#20 o_scl = 1'b0;
		#20;
	endtask
	// Releasing the line while the clock is low lets one task serve start and repeated start.
	task automatic start;
		o_sda_pull = 1'b0;
		#20 o_scl = 1'b1;
		#20 o_sda_pull = 1'b1;
		#20 o_scl = 1'b0;
		#20;
	endtask
	task automatic stop;
		o_sda_pull = 1'b1;
		#20 o_scl = 1'b1;
		#20 o_sda_pull = 1'b0;
		#20;
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic n;
		for (int i = 7; i >= 0; i--) put_bit(b[i]);
		get_bit(n);
		ack = !n;
	endtask
	task automatic recv(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) get_bit(b[i]);
		put_bit(last);
	endtask
endmodule
`default_nettype wire

// ===== test_i2c_target_register_read.sv
// Self-checking bench for the register-read target port.
`timescale 1ns/100ps
`default_nettype none
module test_i2c_target_register_read
	import fg_read_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b1;
	logic clk_en = 1'b1;
	logic scl, pull, sda_o, sda_oe, rd_en;
	logic [7:0] rd_addr;
	int fails = 0;
	int checked = 0;
	wire logic sda = (sda_oe ? sda_o : 1'b1) & !pull;
	wire logic [7:0] rd_data = rd_addr ^ 8'hA5;
	always #12.5 clk = !clk;
	i2c_target_register_read u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_scl(scl), .i_sda(sda),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_rd_data(rd_data), .o_rd_en(rd_en), .o_rd_addr(rd_addr));
	fg_host_model u_host (.i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
	function automatic logic [7:0] map_byte(input logic [8:0] a);
		return a[8] ? PAST_TOP_BYTE : a[7:0] ^ 8'hA5;
	endfunction
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t ack %b expected %b", $time, got, exp);
		end
	endtask
	task automatic do_read(input logic [7:0] ptr, input int n);
		logic a;
		logic [7:0] b;
		u_host.start();
		u_host.send({TARGET_ADDR, 1'b0}, a);
		cmp_bit(a, 1'b1);
		u_host.send(ptr, a);
		cmp_bit(a, 1'b1);
		u_host.start();
		u_host.send({TARGET_ADDR, RW_READ}, a);
		cmp_bit(a, 1'b1);
		for (int k = 0; k < n; k++) begin
			u_host.recv(k == n - 1, b);
			cmp_byte(b, map_byte({1'b0, ptr} + 9'(k)));
		end
	endtask
	task automatic seq_then_release;
		logic [7:0] b;
		do_read(8'h02, 3);
		u_host.recv(1'b1, b);
		cmp_byte(b, 8'hFF);
		u_host.stop();
	endtask
	task automatic past_top;
		do_read(8'hFE, 4);
	endtask
	// The start here follows a NAK directly, so it doubles as a repeated start.
	task automatic wrong_target;
		logic a;
		logic [7:0] b;
		u_host.start();
		u_host.send({7'h37, RW_READ}, a);
		cmp_bit(a, 1'b0);
		u_host.recv(1'b1, b);
		cmp_byte(b, 8'hFF);
		u_host.stop();
	endtask
	// A zero byte right after the address ack keeps the line low for nine clocks in a row.
	task automatic zero_run;
		do_read(8'hA5, 2);
	endtask
	// The pointer write lands while the system side is frozen, so its fetch waits for the enable.
	task automatic frozen_fetch;
		logic a;
		logic [7:0] b;
		@(posedge clk);
		#1 clk_en = 1'b0;
		u_host.start();
		u_host.send({TARGET_ADDR, 1'b0}, a);
		cmp_bit(a, 1'b1);
		u_host.send(8'h10, a);
		cmp_bit(a, 1'b1);
		repeat (4) @(posedge clk);
		#1 cmp_bit(rd_en, 1'b0);
		clk_en = 1'b1;
		repeat (3) @(posedge clk);
		#1 cmp_bit(rd_en, 1'b1);
		cmp_byte(rd_addr, 8'h10);
		u_host.start();
		u_host.send({TARGET_ADDR, RW_READ}, a);
		cmp_bit(a, 1'b1);
		u_host.recv(1'b1, b);
		cmp_byte(b, map_byte(9'h010));
		u_host.stop();
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		tally_and_finish();
	end
	// Reset gets a real falling edge, so the serial-clock flops clear before the first frame.
	initial begin
		#1 rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		seq_then_release();
		past_top();
		wrong_target();
		zero_run();
		frozen_fetch();
		tally_and_finish();
	end
endmodule
`default_nettype wire
